// >>> hdl/order_code_sequencer.sv
`timescale 1ns/1ps
module order_code_sequencer
	import seq_pkg::*;
#(
	parameter int ADDR_W        = 8,
	parameter int COUNTER_LINES = 4
)
(
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire logic [ADDR_W-1:0]        awaddr,
	input  wire logic                     awvalid,
	output logic                          awready,
	input  wire logic [31:0]              wdata,
	input  wire logic [3:0]               wstrb,
	input  wire logic                     wvalid,
	output logic                          wready,
	output logic [1:0]                    bresp,
	output logic                          bvalid,
	input  wire logic                     bready,
	input  wire logic [ADDR_W-1:0]        araddr,
	input  wire logic                     arvalid,
	output logic                          arready,
	output logic [31:0]                   rdata,
	output logic [1:0]                    rresp,
	output logic                          rvalid,
	input  wire logic                     rready,
	input  wire logic [16:1]              write_lines,
	input  wire logic                     start_order,
	input  wire logic                     interrupt_order,
	input  wire logic                     xfer_order,
	input  wire logic [COUNTER_LINES-1:0] counter_request,
	output logic [1:0]                    read_pulses,
	output logic                          write_pulse,
	output logic [1:0]                    exchange_pulses,
	output logic [COUNTER_LINES-1:0]      counter_pulses,
	output logic [6:0]                    order_code,
	output logic [2:0]                    phase_code
);
	if (ADDR_W < 8 || ADDR_W > 32)
	begin : g_bad_addr
		$error("ADDR_W must be 8 to 32");
	end
	if (COUNTER_LINES < 1)
	begin : g_bad_lines
		$error("COUNTER_LINES must be at least 1");
	end

	time_pulse_if tp_bus ();

	time_pulse_gen u_time_pulse (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tp      (tp_bus)
	);

	logic [6:0]              order_code_reg;
	logic [2:0]              phase_code_reg;
	logic [1:0]              branch_reg;
	logic                    ending_reg;
	logic                    ext_pending_reg;
	logic                    run_reg;
	logic [15:0]             done_count_reg;
	logic [NUM_CP-1:0]       cp_reg;
	logic [NUM_CP-1:0]       cp_n;
	logic [COUNTER_LINES-1:0] counter_pulses_reg;
	logic [NUM_ACTIONS-1:0]  act;
	logic [15:0]             tp_hot;
	logic [7:0]              hot;
	logic [3:0]              stage_bin;
	logic [5:0]              stage_gray;
	logic [1:0]              target;
	logic                    divide;
	logic                    branch_cmd;
	logic                    last;
	logic                    busy;
	logic                    is_extend;
	logic                    prio;
	logic                    overflow;
	logic                    zero;

	assign tp_bus.run = run_reg;
	assign prio       = start_order | interrupt_order | xfer_order;

	// Command generator
	assign tp_hot     = tp_bus.strobe ? slot_hot(tp_bus.slot) : 16'h0000;
	assign hot        = stage_hot(phase_code_reg);
	assign divide     = order_code_reg[EXT_BIT] &
		(order_code_reg[5:3] == DIVIDE_OPCODE);
	assign is_extend  = (order_code_reg == ORDER_EXTEND_CODE);
	assign branch_cmd = ~order_code_reg[EXT_BIT] & hot[0] &
		(order_code_reg[5:3] == BRANCH_OPCODE);
	assign stage_bin  = hot[3:0] & {4{~divide}};
	assign stage_gray = {hot[4], hot[6], hot[7], hot[3], hot[1], hot[0]}
		& {6{divide}};
	assign last       = divide ? hot[PHASE_DIVIDE_END] :
		stage_bin[order_code_reg[1:0]];
	assign target     = phase_code_reg[1:0] + 2'h1;
	assign busy       = ~ending_reg;

	// Crosspoint generator
	always_comb
	begin
		act = '0;
		act[ACT_HOLD_READ]     = busy & last & tp_hot[SLOT_CLEAR];
		act[ACT_LOAD]          = ending_reg & tp_hot[SLOT_LOAD];
		act[ACT_OPERAND_READ]  = busy & ~last & tp_hot[SLOT_OPERAND_READ];
		act[ACT_OPERAND_WRITE] = busy & ~last & tp_hot[SLOT_OPERAND_WRITE];
		act[ACT_TEST]          = busy & branch_cmd & tp_hot[SLOT_TEST];
		act[ACT_BR_POS]        = busy & branch_cmd & ~branch_reg[1]
			& tp_hot[SLOT_BRANCH];
		act[ACT_BR_NEG]        = busy & branch_cmd & branch_reg[1]
			& tp_hot[SLOT_BRANCH];
		act[ACT_ADV_A]         = busy & ~last & ~divide & target[0]
			& tp_hot[TIME_PULSE_LAST];
		act[ACT_ADV_B]         = busy & ~last & tp_hot[TIME_PULSE_LAST]
			& (divide ? hot[PHASE_GRAY_LAST] : target[1]);
		act[ACT_DIV_ADV]       = busy & ~last & ~hot[PHASE_GRAY_LAST]
			& (|stage_gray) & tp_hot[TIME_PULSE_LAST];
	end

	// One NOR gate per control pulse
	for (genvar i = 0; i < NUM_CP; i++)
	begin : g_cp_gate
		assign cp_n[i] = ~|(act & CP_MAP[i]);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cp_reg <= '0;
		else
			cp_reg <= ~cp_n;
	end

	// Grouped distribution
	assign read_pulses     = cp_reg[CP_OPERAND_READ:CP_HOLD_READ];
	assign write_pulse     = cp_reg[CP_OPERAND_WRITE];
	assign exchange_pulses = cp_reg[CP_EXCH_NEG:CP_EXCH_POS];
	assign order_code      = order_code_reg;
	assign phase_code      = phase_code_reg;
	assign counter_pulses  = counter_pulses_reg;

	// Order register; priority codes win over the load sequence
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			order_code_reg  <= ORDER_CLEAR_CODE;
			ext_pending_reg <= 1'b0;
		end
		else if (start_order || xfer_order)
		begin
			order_code_reg  <= ORDER_CLEAR_CODE;
			ext_pending_reg <= 1'b0;
		end
		else if (interrupt_order)
		begin
			order_code_reg  <= ORDER_INTERRUPT_CODE;
			ext_pending_reg <= 1'b0;
		end
		else if (cp_reg[CP_ORDER_CLEAR])
		begin
			order_code_reg  <= ORDER_CLEAR_CODE;
			ext_pending_reg <= is_extend;
		end
		else if (cp_reg[CP_ORDER_WRITE])
			order_code_reg  <= {ext_pending_reg, write_lines[16],
				write_lines[14:10]};
	end

	// Load sequence in progress: commands from a cleared code are ignored
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ending_reg <= 1'b0;
		else if (prio || cp_reg[CP_ORDER_WRITE])
			ending_reg <= 1'b0;
		else if (cp_reg[CP_ORDER_CLEAR])
			ending_reg <= 1'b1;
	end

	// Phase counter
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			phase_code_reg <= PHASE_IDLE;
		else if (start_order)
			phase_code_reg <= PHASE_START;
		else if (xfer_order)
			phase_code_reg <= PHASE_XFER;
		else if (interrupt_order)
			phase_code_reg <= PHASE_INTERRUPT;
		else if (cp_reg[CP_ORDER_WRITE])
			phase_code_reg <= PHASE_IDLE;
		else if (cp_reg[CP_PHASE_ADVANCE_B] && divide)
			phase_code_reg <= PHASE_DIVIDE_END;
		else if (cp_reg[CP_DIVIDE_ADVANCE])
			phase_code_reg <= gray_next(phase_code_reg);
		else if (cp_reg[CP_PHASE_ADVANCE_A] || cp_reg[CP_PHASE_ADVANCE_B])
			phase_code_reg <= {1'b0, cp_reg[CP_PHASE_ADVANCE_B],
				cp_reg[CP_PHASE_ADVANCE_A]};
	end

	// Branch control
	assign overflow = write_lines[16] ^ write_lines[15];
	assign zero     = (write_lines == 16'h0000) || (write_lines == 16'hFFFF);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			branch_reg <= 2'h0;
		else if (cp_reg[CP_TEST] && overflow)
			branch_reg <= {write_lines[16], write_lines[15]};
		else if (cp_reg[CP_TEST])
			branch_reg <= {write_lines[16], zero};
	end

	// Counter control, one gate per location
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			counter_pulses_reg <= '0;
		else
			counter_pulses_reg <= counter_request
				& {COUNTER_LINES{tp_hot[SLOT_COUNTER]}};
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			done_count_reg <= 16'h0000;
		else if (cp_reg[CP_ORDER_WRITE])
			done_count_reg <= done_count_reg + 16'h0001;
	end

	// AXI4-Lite slave
	function automatic logic addr_is(input logic [ADDR_W-1:0] a,
		input logic [7:0] r);
		addr_is = ({a[ADDR_W-1:2], 2'b00} == ADDR_W'(r));
	endfunction : addr_is

	logic [ADDR_W-1:0] aw_addr_reg;
	logic              aw_have_reg;
	logic              w_have_reg;
	logic [31:0]       w_data_reg;
	logic [3:0]        w_strb_reg;

	// Write path holds ready low until the response is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready     <= 1'b1;
			wready      <= 1'b1;
			bvalid      <= 1'b0;
			bresp       <= AXI_OKAY;
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg  <= 32'h00000000;
			w_strb_reg  <= 4'h0;
			run_reg     <= CTRL_RUN_RESET;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_addr_reg <= awaddr;
				aw_have_reg <= 1'b1;
				awready     <= 1'b0;
			end
			if (wvalid && wready)
			begin
				w_data_reg <= wdata;
				w_strb_reg <= wstrb;
				w_have_reg <= 1'b1;
				wready     <= 1'b0;
			end
			if (aw_have_reg && w_have_reg && !bvalid)
			begin
				aw_have_reg <= 1'b0;
				w_have_reg  <= 1'b0;
				bvalid      <= 1'b1;
				if (addr_is(aw_addr_reg, REG_CTRL))
				begin
					bresp <= AXI_OKAY;
					if (w_strb_reg[0])
						run_reg <= w_data_reg[0];
				end
				else if (addr_is(aw_addr_reg, REG_STATUS) ||
					addr_is(aw_addr_reg, REG_COUNT))
					bresp <= AXI_OKAY;
				else
					bresp <= AXI_SLVERR;
			end
			if (bvalid && bready)
			begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= AXI_OKAY;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= AXI_OKAY;
			if (addr_is(araddr, REG_CTRL))
				rdata <= {31'h0, run_reg};
			else if (addr_is(araddr, REG_STATUS))
				rdata <= {18'h0, branch_reg, 1'b0, phase_code_reg,
					1'b0, order_code_reg};
			else if (addr_is(araddr, REG_COUNT))
				rdata <= {16'h0000, done_count_reg};
			else
			begin
				rdata <= 32'h00000000;
				rresp <= AXI_SLVERR;
			end
		end
		else if (rvalid && rready)
		begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	interrupt_preset_a: assert property (
		interrupt_order && !start_order && !xfer_order
		|=> order_code_reg == ORDER_INTERRUPT_CODE
			&& phase_code_reg == PHASE_INTERRUPT)
		else $error("interrupt code did not preset order and phase");

	start_preset_a: assert property (
		start_order |=> order_code_reg == ORDER_CLEAR_CODE
			&& phase_code_reg == PHASE_START)
		else $error("start code did not clear order and preset phase");

	xfer_preset_a: assert property (
		xfer_order && !start_order |=> order_code_reg == ORDER_CLEAR_CODE
			&& phase_code_reg == PHASE_XFER)
		else $error("transfer code did not preset phase 011");

	order_load_a: assert property (
		cp_reg[CP_ORDER_WRITE] && !prio |=> order_code_reg[5:0] ==
			{$past(write_lines[16]), $past(write_lines[14:10])}
			&& phase_code_reg == PHASE_IDLE)
		else $error("order register did not load write lines");

	load_sequence_a: assert property (
		cp_reg[CP_ORDER_CLEAR] && !prio |-> read_pulses[0]
		##1 order_code_reg == ORDER_CLEAR_CODE && ending_reg)
		else $error("clear did not go with holding read");

	divide_gray_a: assert property (
		cp_reg[CP_DIVIDE_ADVANCE] && !prio && !cp_reg[CP_ORDER_WRITE]
		|=> phase_code_reg == gray_next($past(phase_code_reg)))
		else $error("divide advance left the Gray sequence");

	divide_end_a: assert property (
		cp_reg[CP_PHASE_ADVANCE_B] && divide && !prio
		&& !cp_reg[CP_ORDER_WRITE] |=> phase_code_reg == PHASE_DIVIDE_END)
		else $error("divide did not finish at phase 010");

	phase_hold_a: assert property (
		!prio && !cp_reg[CP_ORDER_WRITE] && !cp_reg[CP_PHASE_ADVANCE_A]
		&& !cp_reg[CP_PHASE_ADVANCE_B] && !cp_reg[CP_DIVIDE_ADVANCE]
		|=> $stable(phase_code_reg))
		else $error("phase changed without a cause");

	overflow_capture_a: assert property (
		cp_reg[CP_TEST] && overflow
		|=> branch_reg == {$past(write_lines[16]), $past(write_lines[15])})
		else $error("overflow bits not captured directly");

	counter_route_a: assert property (
		counter_request[0] && tp_hot[SLOT_COUNTER] |=> counter_pulses[0])
		else $error("counter request not routed at its slot");

	crosspoint_time_a: assert property (
		cp_reg[CP_ORDER_CLEAR] |-> $past(tp_hot[SLOT_CLEAR]))
		else $error("clear pulse outside its time pulse");

	load_done_c: cover property (cp_reg[CP_ORDER_WRITE] && !prio);
	branch_neg_c: cover property (exchange_pulses[1]);
	divide_walk_c: cover property (cp_reg[CP_DIVIDE_ADVANCE]
		##[1:300] cp_reg[CP_PHASE_ADVANCE_B]);
	write_resp_c: cover property (bvalid && bready);

endmodule : order_code_sequencer

// >>> inc/seq_pkg.sv
package seq_pkg;

	// Timing
	localparam int CLK_PERIOD_NS        = 4;
	localparam int MEMORY_CYCLE_TIME_NS = 11700;
	localparam int TIME_PULSE_COUNT     = 12;
	// Longest time per slot, so rounded down
	localparam int TIME_PULSE_CYCLES    =
		MEMORY_CYCLE_TIME_NS / (TIME_PULSE_COUNT * CLK_PERIOD_NS);

	// Time pulse slots
	localparam logic [3:0] TIME_PULSE_FIRST   = 4'h1;
	localparam logic [3:0] TIME_PULSE_LAST    = 4'hC;
	localparam logic [3:0] SLOT_OPERAND_READ  = 4'h2;
	localparam logic [3:0] SLOT_COUNTER       = 4'h3;
	localparam logic [3:0] SLOT_TEST          = 4'h5;
	localparam logic [3:0] SLOT_BRANCH        = 4'h6;
	localparam logic [3:0] SLOT_OPERAND_WRITE = 4'h8;
	localparam logic [3:0] SLOT_CLEAR         = 4'hA;
	localparam logic [3:0] SLOT_LOAD          = 4'hB;

	// Order codes and fields
	localparam logic [6:0] ORDER_CLEAR_CODE     = 7'h00;
	localparam logic [6:0] ORDER_INTERRUPT_CODE = 7'h47;
	localparam logic [6:0] ORDER_EXTEND_CODE    = 7'h06;
	localparam int         EXT_BIT              = 6;
	localparam logic [2:0] DIVIDE_OPCODE        = 3'h1;
	localparam logic [2:0] BRANCH_OPCODE        = 3'h2;

	// Phase codes
	localparam logic [2:0] PHASE_IDLE       = 3'h0;
	localparam logic [2:0] PHASE_INTERRUPT  = 3'h0;
	localparam logic [2:0] PHASE_START      = 3'h1;
	localparam logic [2:0] PHASE_XFER       = 3'h3;
	localparam logic [2:0] PHASE_DIVIDE_END = 3'h2;
	localparam logic [2:0] PHASE_GRAY_LAST  = 3'h4;

	// Action pulses
	localparam int ACT_HOLD_READ     = 0;
	localparam int ACT_LOAD          = 1;
	localparam int ACT_OPERAND_READ  = 2;
	localparam int ACT_OPERAND_WRITE = 3;
	localparam int ACT_TEST          = 4;
	localparam int ACT_BR_POS        = 5;
	localparam int ACT_BR_NEG        = 6;
	localparam int ACT_ADV_A         = 7;
	localparam int ACT_ADV_B         = 8;
	localparam int ACT_DIV_ADV       = 9;
	localparam int NUM_ACTIONS       = 10;

	// Control pulses, grouped read, write, exchange, test, special
	localparam int CP_HOLD_READ       = 0;
	localparam int CP_OPERAND_READ    = 1;
	localparam int CP_OPERAND_WRITE   = 2;
	localparam int CP_EXCH_POS        = 3;
	localparam int CP_EXCH_NEG        = 4;
	localparam int CP_TEST            = 5;
	localparam int CP_ORDER_CLEAR     = 6;
	localparam int CP_ORDER_WRITE     = 7;
	localparam int CP_PHASE_ADVANCE_A = 8;
	localparam int CP_PHASE_ADVANCE_B = 9;
	localparam int CP_DIVIDE_ADVANCE  = 10;
	localparam int NUM_CP             = 11;

	// Actions feeding each control pulse gate
	localparam logic [NUM_ACTIONS-1:0] CP_MAP [NUM_CP] = '{
		10'h001, 10'h014, 10'h008, 10'h020, 10'h040, 10'h010,
		10'h001, 10'h002, 10'h080, 10'h100, 10'h200
	};

	// Registers
	localparam logic [7:0] REG_CTRL         = 8'h00;
	localparam logic [7:0] REG_STATUS       = 8'h04;
	localparam logic [7:0] REG_COUNT        = 8'h08;
	localparam logic       CTRL_RUN_RESET   = 1'b1;
	localparam logic [1:0] AXI_OKAY         = 2'h0;
	localparam logic [1:0] AXI_SLVERR       = 2'h2;

	function automatic logic [2:0] gray_next(input logic [2:0] p);
		unique case (p)
			3'h0:    gray_next = 3'h1;
			3'h1:    gray_next = 3'h3;
			3'h3:    gray_next = 3'h7;
			3'h7:    gray_next = 3'h6;
			3'h6:    gray_next = 3'h4;
			3'h4:    gray_next = 3'h4;
			default: gray_next = 3'h0;
		endcase
	endfunction : gray_next

	function automatic logic [7:0] stage_hot(input logic [2:0] p);
		stage_hot = 8'h01 << p;
	endfunction : stage_hot

	function automatic logic [15:0] slot_hot(input logic [3:0] s);
		slot_hot = 16'h0001 << s;
	endfunction : slot_hot

endpackage : seq_pkg

// >>> inc/time_pulse_if.sv
`timescale 1ns/1ps
interface time_pulse_if;
	logic       run;
	logic       strobe;
	logic [3:0] slot;
	modport source (input run, output strobe, output slot);
	modport sink   (output run, input strobe, input slot);
endinterface : time_pulse_if

// >>> hdl/time_pulse_gen.sv
`timescale 1ns/1ps
module time_pulse_gen
	import seq_pkg::*;
#(
	parameter int STEP_CYCLES = TIME_PULSE_CYCLES
)
(
	input wire logic     aclk,
	input wire logic     aresetn,
	time_pulse_if.source tp
);
	localparam int CW = $clog2(STEP_CYCLES + 1);

	if (STEP_CYCLES < 2)
	begin : g_bad_step
		$error("STEP_CYCLES must be at least 2");
	end

	logic [CW-1:0] step_count_reg;
	logic [3:0]    slot_reg;
	logic          strobe_reg;

	// Stop freezes the slot so word flow resumes where it halted
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			step_count_reg <= '0;
			slot_reg       <= TIME_PULSE_LAST;
			strobe_reg     <= 1'b0;
		end
		else if (!tp.run)
		begin
			step_count_reg <= '0;
			strobe_reg     <= 1'b0;
		end
		else if (step_count_reg == CW'(STEP_CYCLES - 1))
		begin
			step_count_reg <= '0;
			strobe_reg     <= 1'b1;
			slot_reg       <= (slot_reg == TIME_PULSE_LAST) ?
				TIME_PULSE_FIRST : slot_reg + 4'h1;
		end
		else
		begin
			step_count_reg <= step_count_reg + CW'(1);
			strobe_reg     <= 1'b0;
		end
	end

	assign tp.strobe = strobe_reg;
	assign tp.slot   = slot_reg;

	slot_range_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		slot_reg >= TIME_PULSE_FIRST && slot_reg <= TIME_PULSE_LAST)
		else $error("time pulse slot out of range");

	slot_wrap_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		strobe_reg && slot_reg == TIME_PULSE_FIRST
		|-> $past(slot_reg) == TIME_PULSE_LAST ##1 !strobe_reg)
		else $error("time pulse sequence did not wrap after last");

	cycle_end_c: cover property (
		@(posedge aclk) disable iff (!aresetn)
		strobe_reg && slot_reg == TIME_PULSE_LAST);

endmodule : time_pulse_gen

// >>> dv/datapath_model.sv
`timescale 1ns/1ps
module datapath_model
(
	input  wire logic        aclk,
	input  wire logic [1:0]  read_pulses,
	input  wire logic [16:1] holding,
	output logic [16:1]      write_lines
);
	int          hold_cnt = 0;
	logic [16:1] idle_pat = 16'hA5C3;
	// Idle lines flip each cycle so stale data cannot pass
	assign write_lines = (read_pulses[0] || hold_cnt > 0) ? holding : idle_pat;
	always @(posedge aclk)
	begin
		idle_pat <= ~idle_pat;
		// Held well past the load slot
		if (read_pulses[0])
			hold_cnt <= 600;
		else if (hold_cnt > 0)
			hold_cnt <= hold_cnt - 1;
	end
endmodule : datapath_model

// >>> dv/tb_order_code_sequencer.sv
`timescale 1ns/1ps
module tb_order_code_sequencer
	import seq_pkg::*;
;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, write_pulse;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb, counter_request, counter_pulses, seen;
	logic [1:0]  bresp, rresp, read_pulses, exchange_pulses;
	logic [16:1] write_lines, holding;
	logic [2:0]  pri, phase_code, ph_last;
	logic [6:0]  order_code, exp_order;
	logic [9:0]  ptab [3];
	logic [2:0]  ph_q [$];
	int          err_total, checks, seed, cyc, last_cp, gap, i;
	int          wp_cnt, ex_cnt;

	order_code_sequencer u_dut (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.write_lines(write_lines), .start_order(pri[0]),
		.interrupt_order(pri[1]), .xfer_order(pri[2]),
		.counter_request(counter_request), .read_pulses(read_pulses),
		.write_pulse(write_pulse), .exchange_pulses(exchange_pulses),
		.counter_pulses(counter_pulses), .order_code(order_code),
		.phase_code(phase_code));
	datapath_model u_dp (.aclk(aclk), .read_pulses(read_pulses),
		.holding(holding), .write_lines(write_lines));

	always #2 aclk = ~aclk;

	task end_sim;
		$display("checks=%0d mismatches=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim

	// Phase walk, counter gates and memory cycle spacing
	always @(posedge aclk)
	begin
		cyc++;
		seen |= counter_pulses;
		wp_cnt += write_pulse;
		ex_cnt += (exchange_pulses != 2'h0);
		if (counter_pulses[0])
		begin
			gap = cyc - last_cp;
			last_cp = cyc;
		end
		if (phase_code !== ph_last)
			ph_q.push_back(phase_code);
		ph_last = phase_code;
		if (cyc == 40000)
		begin
			err_total++;
			end_sim();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ad, dd;
		ad = 1'b0;
		dd = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && dd))
		begin
			@(posedge aclk);
			if (awready && !ad)
			begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !dd)
			begin
				dd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (!bvalid)
			@(posedge aclk);
		bready <= 1'b0;
		chk(bresp, er);
	endtask : axi_wr

	task axi_rd(input logic [7:0] a, output logic [31:0] d,
		input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(posedge aclk);
		while (!arready)
			@(posedge aclk);
		arvalid <= 1'b0;
		@(posedge aclk);
		while (!rvalid)
			@(posedge aclk);
		d = rdata;
		rready <= 1'b0;
		chk(rresp, er);
	endtask : axi_rd

	initial
	begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, pri, ph_last} = '0;
		wstrb = 4'hF;
		seed = 39;
		// holding[11] set so the loaded code never equals the cleared code
		holding = $random(seed) | 16'h0400;
		counter_request = $random(seed) | 4'h1;
		ptab = '{{ORDER_CLEAR_CODE, PHASE_START},
			{ORDER_INTERRUPT_CODE, PHASE_INTERRUPT},
			{ORDER_CLEAR_CODE, PHASE_XFER}};
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({order_code, phase_code}, 32'h0);
		axi_rd(REG_CTRL, rd, AXI_OKAY);
		chk(rd, 32'h1);
		axi_rd(8'h10, rd, AXI_SLVERR);
		chk(rd, 32'h0);
		axi_wr(8'h10, 32'h0, AXI_SLVERR);
		axi_wr(REG_COUNT, 32'hFFFF, AXI_OKAY);
		axi_rd(REG_COUNT, rd, AXI_OKAY);
		chk(rd, 32'h0);
		$display("test registers done");
		for (i = 0; i < 3; i++)
		begin
			@(posedge aclk) pri <= 3'h1 << i;
			@(posedge aclk) pri <= 3'h0;
			#1 chk({order_code, phase_code}, ptab[i]);
		end
		$display("test priority codes done");
		@(posedge aclk) pri <= 3'h2;
		@(posedge aclk) pri <= 3'h0;
		exp_order = {1'b0, holding[16], holding[14:10]};
		seen = '0;
		wp_cnt = 0;
		ex_cnt = 0;
		ph_q.delete();
		i = 0;
		while (order_code !== exp_order && i < 16000)
		begin
			@(posedge aclk);
			i++;
		end
		#1 chk({order_code, phase_code}, {exp_order, PHASE_IDLE});
		chk(ph_q.size(), 32'h5);
		chk({ph_q[1], ph_q[2], ph_q[3], ph_q[4]}, 12'h298);
		chk(seen, counter_request);
		chk(ex_cnt, 32'h0);
		chk(wp_cnt >= 2 && wp_cnt <= 4, 32'h1);
		chk(gap, TIME_PULSE_COUNT * TIME_PULSE_CYCLES);
		axi_rd(REG_COUNT, rd, AXI_OKAY);
		chk(rd, 32'h1);
		axi_rd(REG_STATUS, rd, AXI_OKAY);
		chk(rd & 32'h7FF, {PHASE_IDLE, 1'b0, exp_order});
		$display("test instruction load done");
		axi_wr(REG_CTRL, 32'h0, AXI_OKAY);
		repeat (5) @(posedge aclk);
		seen = '0;
		repeat (3000) @(posedge aclk);
		chk(seen, 32'h0);
		chk({order_code, phase_code}, {exp_order, PHASE_IDLE});
		axi_rd(REG_CTRL, rd, AXI_OKAY);
		chk(rd, 32'h0);
		$display("test stop done");
		end_sim();
	end
endmodule : tb_order_code_sequencer
